// ===== rtl/dst_regs.vh
`ifndef DST_REGS_VH
`define DST_REGS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DST_OFF_TIMING_A   8'hf8
`define DST_OFF_TIMING_B   8'hfc
`define DST_OFF_CTRL       8'he0
`define DST_OFF_STATUS     8'he4
// ----------------------------------------------------------------
// Field positions (low bit) in timing A
// ----------------------------------------------------------------
`define DST_RD2ACT_LSB     28
`define DST_REFRESH_RECOVERY_GAP_LSB     24
`define DST_READ_DATA_LATENCY_LSB      20
`define DST_RASREF_LSB     15
`define DST_CASPG_LSB      12
`define DST_CP_LSB         9
`define DST_CAS1_LSB       6
`define DST_RCD_LSB        3
`define DST_RP_LSB         0
// ----------------------------------------------------------------
// Field positions in timing B
// ----------------------------------------------------------------
`define DST_PRE2ACT_LSB    28
`define DST_ACT2PRE_LSB    24
// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define DST_RST_TIMING_A   32'h00000000
`define DST_RST_TIMING_B   32'h00000000
`define DST_MASK_TIMING_A  32'hfff7ffff
`define DST_MASK_TIMING_B  32'hff000000
`define DST_RST_CTRL       32'h00000000
`endif

// ===== rtl/dst_counter.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Interval down-counter: load a coded count, flag expiry
// ----------------------------------------------------------------
module dst_counter #(
    parameter W = 4
) (
    core_clk,
    rst_n,
    load,
    code,
    busy
);
    input  wire         core_clk;
    input  wire         rst_n;
    input  wire         load;
    input  wire [W-1:0] code;
    output wire         busy;

    reg [W:0] cnt_q;

    // Code zero stands for the largest count, 2**W
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {(W+1){1'b0}};
        end else if (load) begin
            cnt_q <= (code == {W{1'b0}}) ? {1'b1, {W{1'b0}}} : {1'b0, code};
        end else if (cnt_q != {(W+1){1'b0}}) begin
            cnt_q <= cnt_q - {{W{1'b0}}, 1'b1};
        end
    end

    assign busy = (cnt_q != {(W+1){1'b0}});
endmodule

// ===== rtl/dst_timing.v
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
// Functional notes
// - SDRAM: read with autoprecharge blocks activate for coded clocks, 0 means 16.
// - SDRAM: refresh blocks activate for coded clocks, 0 means 16.
// - SDRAM: first read beat expected coded clocks after read, 0 means 16.
// - DRAM: CBR refresh holds row strobe coded clocks, 0 means 16.
// - DRAM: page-mode column strobe asserted coded clocks, 0 means 8.
// - DRAM: page-mode column strobe negated coded clocks before reassert, 0 means 8.
// - DRAM: first or single access column strobe asserted coded clocks, 0 means 8.
// - DRAM: coded clocks from row strobe assertion to first column strobe.
// - DRAM: row strobe negated coded clocks before next assertion, 0 means 8.
// - SDRAM: precharge blocks activate for coded clocks, 0 means 16.
// - SDRAM: activate blocks precharge for coded clocks, 0 means 16.
`include "dst_regs.vh"

module dst_timing (
    core_clk,
    arst_n,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    sd_read_ap,
    sd_refresh,
    sd_precharge,
    sd_activate,
    dr_ras_rise,
    dr_ras_fall,
    dr_cas_rise,
    dr_cas_fall,
    dr_cbr,
    dr_page,
    sd_act_ok,
    sd_pre_ok,
    sd_data_due,
    dr_ras_on_ok,
    dr_ras_off_ok,
    dr_cas_on_ok,
    dr_cas_off_ok
);
    input  wire        core_clk;
    input  wire        arst_n;
    input  wire        wb_cyc_i;
    input  wire        wb_stb_i;
    input  wire        wb_we_i;
    input  wire [7:0]  wb_adr_i;
    input  wire [3:0]  wb_sel_i;
    input  wire [31:0] wb_dat_i;
    output reg  [31:0] wb_dat_o;
    output reg         wb_ack_o;
    input  wire        sd_read_ap;
    input  wire        sd_refresh;
    input  wire        sd_precharge;
    input  wire        sd_activate;
    input  wire        dr_ras_rise;
    input  wire        dr_ras_fall;
    input  wire        dr_cas_rise;
    input  wire        dr_cas_fall;
    input  wire        dr_cbr;
    input  wire        dr_page;
    output reg         sd_act_ok;
    output reg         sd_pre_ok;
    output reg         sd_data_due;
    output reg         dr_ras_on_ok;
    output reg         dr_ras_off_ok;
    output reg         dr_cas_on_ok;
    output reg         dr_cas_off_ok;

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    reg rst_s1_q;
    reg rst_n_q;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [31:0] timing_a_q;
    reg  [31:0] timing_b_q;
    wire [31:0] status_w;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        input [31:0] mask;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
            merge = merge & mask;
        end
    endfunction

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Ack one cycle after the request; unmapped reads return zero, writes dropped
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timing_a_q <= `DST_RST_TIMING_A;
            timing_b_q <= `DST_RST_TIMING_B;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && wb_we_i) begin
                if (wb_adr_i == `DST_OFF_TIMING_A) begin
                    timing_a_q <= merge(timing_a_q, wb_dat_i, wb_sel_i, `DST_MASK_TIMING_A);
                end else if (wb_adr_i == `DST_OFF_TIMING_B) begin
                    timing_b_q <= merge(timing_b_q, wb_dat_i, wb_sel_i, `DST_MASK_TIMING_B);
                end
            end
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == `DST_OFF_TIMING_A) begin
                    wb_dat_o <= timing_a_q;
                end else if (wb_adr_i == `DST_OFF_TIMING_B) begin
                    wb_dat_o <= timing_b_q;
                end else if (wb_adr_i == `DST_OFF_STATUS) begin
                    wb_dat_o <= status_w;
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Interval counters
    // ----------------------------------------------------------------
    wire b_rd2act;
    wire b_refresh_recovery_gap;
    wire b_read_data_latency;
    wire b_pre2act;
    wire b_act2pre;
    wire b_rasref;
    wire b_caspg;
    wire b_cp;
    wire b_cas1;
    wire b_rcd;
    wire b_rp;

    dst_counter #(
        .W(4)
    ) u_rd2act (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (sd_read_ap),
        .code     (timing_a_q[`DST_RD2ACT_LSB +: 4]),
        .busy     (b_rd2act)
    );

    dst_counter #(
        .W(4)
    ) u_refresh_recovery_gap (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (sd_refresh),
        .code     (timing_a_q[`DST_REFRESH_RECOVERY_GAP_LSB +: 4]),
        .busy     (b_refresh_recovery_gap)
    );

    dst_counter #(
        .W(4)
    ) u_read_data_latency (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (sd_read_ap),
        .code     (timing_a_q[`DST_READ_DATA_LATENCY_LSB +: 4]),
        .busy     (b_read_data_latency)
    );

    dst_counter #(
        .W(4)
    ) u_pre2act (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (sd_precharge),
        .code     (timing_b_q[`DST_PRE2ACT_LSB +: 4]),
        .busy     (b_pre2act)
    );

    dst_counter #(
        .W(4)
    ) u_act2pre (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (sd_activate),
        .code     (timing_b_q[`DST_ACT2PRE_LSB +: 4]),
        .busy     (b_act2pre)
    );

    dst_counter #(
        .W(4)
    ) u_rasref (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_ras_fall & dr_cbr),
        .code     (timing_a_q[`DST_RASREF_LSB +: 4]),
        .busy     (b_rasref)
    );

    dst_counter #(
        .W(3)
    ) u_caspg (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_cas_fall & dr_page),
        .code     (timing_a_q[`DST_CASPG_LSB +: 3]),
        .busy     (b_caspg)
    );

    dst_counter #(
        .W(3)
    ) u_cp (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_cas_rise & dr_page),
        .code     (timing_a_q[`DST_CP_LSB +: 3]),
        .busy     (b_cp)
    );

    dst_counter #(
        .W(3)
    ) u_cas1 (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_cas_fall & ~dr_page),
        .code     (timing_a_q[`DST_CAS1_LSB +: 3]),
        .busy     (b_cas1)
    );

    dst_counter #(
        .W(3)
    ) u_rcd (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_ras_fall & ~dr_cbr),
        .code     (timing_a_q[`DST_RCD_LSB +: 3]),
        .busy     (b_rcd)
    );

    dst_counter #(
        .W(3)
    ) u_rp (
        .core_clk (core_clk),
        .rst_n    (rst_n_q),
        .load     (dr_ras_rise),
        .code     (timing_a_q[`DST_RP_LSB +: 3]),
        .busy     (b_rp)
    );

    // Read-latency expiry edge marks the first data beat
    reg read_data_latency_busy_q;

    assign status_w = {21'h00000, b_rp, b_rcd, b_cas1, b_cp, b_caspg, b_rasref,
                       b_act2pre, b_pre2act, b_read_data_latency, b_refresh_recovery_gap, b_rd2act};

    // ----------------------------------------------------------------
    // Permission outputs, registered; a trigger in this cycle also blocks
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            read_data_latency_busy_q  <= 1'b0;
            sd_act_ok     <= 1'b0;
            sd_pre_ok     <= 1'b0;
            sd_data_due   <= 1'b0;
            dr_ras_on_ok  <= 1'b0;
            dr_ras_off_ok <= 1'b0;
            dr_cas_on_ok  <= 1'b0;
            dr_cas_off_ok <= 1'b0;
        end else begin
            read_data_latency_busy_q  <= b_read_data_latency;
            sd_act_ok     <= ~(b_rd2act | b_refresh_recovery_gap | b_pre2act | sd_read_ap | sd_refresh | sd_precharge);
            sd_pre_ok     <= ~(b_act2pre | sd_activate);
            sd_data_due   <= read_data_latency_busy_q & ~b_read_data_latency & ~sd_read_ap;
            dr_ras_on_ok  <= ~(b_rp | dr_ras_rise);
            dr_ras_off_ok <= ~(b_rasref | (dr_ras_fall & dr_cbr));
            dr_cas_on_ok  <= ~(b_rcd | b_cp | dr_ras_fall | (dr_cas_rise & dr_page));
            dr_cas_off_ok <= ~(b_caspg | b_cas1 | dr_cas_fall);
        end
    end
endmodule

// ===== test/dst_timing_monitor.sv
`timescale 1ns/100ps
`include "dst_regs.vh"
// ----
// Interval checker
// ----
module dst_timing_monitor (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        sd_read_ap,
    input wire logic        sd_refresh,
    input wire logic        sd_precharge,
    input wire logic        sd_activate,
    input wire logic        sd_data_due,
    input wire logic        dr_ras_rise,
    input wire logic        dr_ras_fall,
    input wire logic        dr_cas_rise,
    input wire logic        dr_cas_fall,
    input wire logic        dr_cbr,
    input wire logic        dr_page,
    input wire logic        sd_act_ok,
    input wire logic        sd_pre_ok,
    input wire logic        dr_ras_on_ok,
    input wire logic        dr_ras_off_ok,
    input wire logic        dr_cas_on_ok,
    input wire logic        dr_cas_off_ok
);
    logic [31:0] ra_q, rb_q;
    logic [10:0] trg_q;
    logic [4:0]  cnt_q [11];
    wire  [10:0] trg = {dr_cas_rise & dr_page, dr_cas_fall & !dr_page, dr_cas_fall & dr_page,
        dr_ras_fall & !dr_cbr, dr_ras_fall & dr_cbr, dr_ras_rise, sd_read_ap, sd_activate,
        sd_precharge, sd_refresh, sd_read_ap};
    // Zero code decodes to the top count: 16 for four bits, 8 for three
    wire  [54:0] len = {2'b00 | (ra_q[11:9] == 3'h0), ra_q[11:9], 2'b00 | (ra_q[8:6] == 3'h0), ra_q[8:6],
        2'b00 | (ra_q[14:12] == 3'h0), ra_q[14:12], 2'b00 | (ra_q[5:3] == 3'h0), ra_q[5:3],
        ra_q[18:15] == 4'h0, ra_q[18:15], 2'b00 | (ra_q[2:0] == 3'h0), ra_q[2:0],
        ra_q[23:20] == 4'h0, ra_q[23:20], rb_q[27:24] == 4'h0, rb_q[27:24],
        rb_q[31:28] == 4'h0, rb_q[31:28], ra_q[27:24] == 4'h0, ra_q[27:24],
        ra_q[31:28] == 4'h0, ra_q[31:28]};
    // Shadows lag one edge, as does the trigger register, so a command may follow a write at once
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ra_q <= `DST_RST_TIMING_A;
            rb_q <= `DST_RST_TIMING_B;
            trg_q <= 11'h000;
            for (int i = 0; i < 11; i++) begin
                cnt_q[i] <= 5'h00;
            end
        end else begin
            trg_q <= trg;
            for (int i = 0; i < 4; i++) begin
                if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[i]) begin
                    if (wb_adr_i == `DST_OFF_TIMING_A) ra_q[i*8+:8] <= wb_dat_i[i*8+:8];
                    if (wb_adr_i == `DST_OFF_TIMING_B) rb_q[i*8+:8] <= wb_dat_i[i*8+:8];
                end
            end
            for (int i = 0; i < 11; i++) begin
                cnt_q[i] <= trg_q[i] ? len[i*5+:5] : cnt_q[i] - {4'h0, cnt_q[i] != 5'h00};
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_ack_once: assert property (s_req |=> s_ack) else $error("bad ack");
    a_read_act_gap: assert property (cnt_q[0] != 5'h00 |-> !sd_act_ok) else $error("act early");
    a_ref_act_gap: assert property (cnt_q[1] != 5'h00 |-> !sd_act_ok) else $error("act early");
    a_pre_act_gap: assert property (cnt_q[2] != 5'h00 |-> !sd_act_ok) else $error("act early");
    a_act_pre_gap: assert property (cnt_q[3] != 5'h00 |-> !sd_pre_ok) else $error("pre early");
    a_read_beat_due: assert property (cnt_q[4] == 5'h01 |=> sd_data_due) else $error("no beat");
    a_row_pre_gap: assert property (cnt_q[5] != 5'h00 |-> !dr_ras_on_ok) else $error("row early");
    a_cbr_row_hold: assert property (cnt_q[6] != 5'h00 |-> !dr_ras_off_ok) else $error("row short");
    a_row_col_gap: assert property (cnt_q[7] != 5'h00 |-> !dr_cas_on_ok) else $error("col early");
    a_page_col_hold: assert property (cnt_q[8] != 5'h00 |-> !dr_cas_off_ok) else $error("col short");
    a_first_col_hold: assert property (cnt_q[9] != 5'h00 |-> !dr_cas_off_ok) else $error("col short");
    a_col_pre_gap: assert property (cnt_q[10] != 5'h00 |-> !dr_cas_on_ok) else $error("col early");
endmodule
bind dst_timing dst_timing_monitor u_mon (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .sd_read_ap, .sd_refresh, .sd_precharge, .sd_activate, .sd_data_due,
    .dr_ras_rise, .dr_ras_fall, .dr_cas_rise, .dr_cas_fall, .dr_cbr, .dr_page, .sd_act_ok, .sd_pre_ok,
    .dr_ras_on_ok, .dr_ras_off_ok, .dr_cas_on_ok, .dr_cas_off_ok);

// ===== test/dst_mem_model.sv
`timescale 1ns/100ps
// ----
// Command source on the memory side
// ----
module dst_mem_model (
    input wire logic [3:0] op,
    output logic     [7:0] pulse
);
    // One strobe per code, so two commands never share a cycle
    assign pulse = (op == 4'h0) ? 8'h00 : 8'h01 << (op - 4'h1);
endmodule

// ===== test/dst_timing_tb_top.sv
`timescale 1ns/100ps
// ----
// Bench top
// ----
module dst_timing_tb_top;
    logic        core_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, wen = 1'b0, cbr = 1'b0, page = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, op = 4'h0;
    logic [31:0] dat = 32'h0;
    wire  [31:0] rdat;
    wire         ack;
    wire  [7:0]  p;
    wire  [6:0]  okv;
    int          err_total = 0, n_checks = 0;
    dst_timing dut (.core_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sd_read_ap(p[0]), .sd_refresh(p[1]),
        .sd_precharge(p[2]), .sd_activate(p[3]), .dr_ras_fall(p[4]), .dr_ras_rise(p[5]), .dr_cas_fall(p[6]),
        .dr_cas_rise(p[7]), .dr_cbr(cbr), .dr_page(page), .sd_act_ok(okv[0]), .sd_pre_ok(okv[1]),
        .dr_ras_on_ok(okv[2]), .dr_ras_off_ok(okv[3]), .dr_cas_on_ok(okv[4]), .dr_cas_off_ok(okv[5]),
        .sd_data_due(okv[6]));
    dst_mem_model u_mem (.op, .pulse(p));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic print_verdict;
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic lim(input bit hit);
        if (hit) begin
            err_total++;
            print_verdict;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // On a read, d is the value expected back
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int i;
        i = 0;
        {cyc, stb, wen, adr, sel, dat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge core_clk);
            i++;
        end while (ack !== 1'b1 && i < 40);
        lim(ack !== 1'b1);
        if (!w) chk("read data", rdat, d);
        {cyc, stb} <= 2'b00;
        @(posedge core_clk);
    endtask
    // Fire one command, count falling-edge samples, one per cycle, until output b allows again
    task automatic gap(input logic [3:0] o, input logic c, input logic g, input int b, input int n);
        int k;
        k = 0;
        repeat (18) @(posedge core_clk);
        {op, cbr, page} <= {o, c, g};
        @(posedge core_clk);
        op <= 4'h0;
        do begin
            @(negedge core_clk);
            k++;
        end while (okv[b] !== 1'b1 && k < 40);
        lim(okv[b] !== 1'b1);
        chk("allow gap", 32'(k), 32'(n + 2));
        @(posedge core_clk);
    endtask
    // Permission outputs stay low through the internal two-edge release
    task automatic rst_scn;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("ok in reset", {25'h0, okv}, 32'h0);
        @(posedge core_clk);
        chk("ok after reset", {25'h0, okv}, 32'h3f);
    endtask
    // Busy flags read back while a refresh gap runs, and clear after it
    task automatic stat_scn;
        op <= 4'h2;
        @(posedge core_clk);
        op <= 4'h0;
        bus(1'b0, 8'he4, 4'hf, 32'h00000002);
        repeat (20) @(posedge core_clk);
        bus(1'b0, 8'he4, 4'hf, 32'h00000000);
    endtask
    task automatic regs_scn;
        bus(1'b0, 8'hf8, 4'hf, 32'h0);
        bus(1'b0, 8'hfc, 4'hf, 32'h0);
        bus(1'b1, 8'hf8, 4'hf, 32'h305f85cc);
        bus(1'b1, 8'hfc, 4'hf, 32'h10ffffff);
        bus(1'b1, 8'hf8, 4'h8, 32'h20ffffff);
        bus(1'b1, 8'h10, 4'hf, 32'hffffffff);
        bus(1'b0, 8'hf8, 4'hf, 32'h205785cc);
        bus(1'b0, 8'hfc, 4'hf, 32'h10000000);
        bus(1'b0, 8'he0, 4'hf, 32'h0);
        bus(1'b0, 8'h10, 4'hf, 32'h0);
    endtask
    task automatic gaps_scn;
        gap(4'h1, 1'b0, 1'b0, 0, 2);
        gap(4'h2, 1'b0, 1'b0, 0, 16);
        gap(4'h1, 1'b0, 1'b0, 6, 5);
        gap(4'h3, 1'b0, 1'b0, 0, 1);
        gap(4'h4, 1'b0, 1'b0, 1, 16);
        gap(4'h5, 1'b1, 1'b0, 3, 15);
        gap(4'h6, 1'b0, 1'b0, 2, 4);
        gap(4'h5, 1'b0, 1'b0, 4, 1);
        gap(4'h7, 1'b0, 1'b1, 5, 8);
        gap(4'h8, 1'b0, 1'b1, 4, 2);
        gap(4'h7, 1'b0, 1'b0, 5, 7);
    endtask
    initial begin
        rst_scn;
        regs_scn;
        gaps_scn;
        stat_scn;
        print_verdict;
    end
endmodule
